// ==== design/iob_host.sv ====
// iob_host: cpu side of the programmed i/o bus (transfer and identify cycles).
// assumes synchronous pins; software drives it over classic wishbone.
//
// Contract
// - transfer carries an eleven-bit register address alone selecting the register
// - transfer runs as three steps; first drives data and address together
// - first step pulses the address strobe so every interface samples it
// - bit 0 zero means input; device flags input, host takes bus data
// - second step only after acknowledge; then holding, then accumulator (the code also moves on after TIMEOUT cycles without one)
// - after input the accumulator holds the addressed register value
// - after output the accumulator keeps its original value
// - switch to requesting level only when running on a lower level (the code switches no level; level choice stays with software)
// - identify used on shared levels 10 to 13, several devices each
// - level 15 holds one device and needs no identify cycle
// - identify puts level on low six address bits with identify strobe
`timescale 1ns/100ps
`default_nettype none
module iob_host #(
    parameter int TIMEOUT = iob_pkg::TIMEOUT_CYC
) (
    input  wire logic                  mclk,
    input  wire logic                  reset,
    input  wire logic [3:0]            wb_adr_i,
    input  wire logic [31:0]           wb_dat_i,
    input  wire logic                  wb_we_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    output logic [31:0]                wb_dat_o,
    output logic                       wb_ack_o,
    output iob_pkg::iob_bus_out_t      bus_o,
    input  wire iob_pkg::iob_bus_in_t  bus_i,
    input  wire logic [iob_pkg::IRQ_LINES-1:0] irq_i
);
    import iob_pkg::*;

    initial begin
        // the wait must outlast the minimum strobe, or the timeout would end every strobe at or before its minimum length
        if (TIMEOUT <= STROBE_CYC || TIMEOUT > 65535) $error("timeout out of range");
    end

    typedef enum logic [1:0] {IOB_IDLE, IOB_STROBE, IOB_HOLD, IOB_ACC} iob_state_t;

    // ==================== registers
    iob_state_t        state_reg, state_next;
    logic [ADDR_W-1:0] addr_reg;
    logic [DATA_W-1:0] acc_reg, hold_reg;
    logic              ident_reg, timeout_reg, input_reg;
    logic [15:0]       cnt_reg;
    logic [31:0]       rdat_reg;
    logic              ack_reg;
    iob_bus_out_t      bus_reg;
    logic [IRQ_LINES-1:0] irq_reg;

    // ==================== wishbone decode
    wire wb_req     = wb_cyc_i && wb_stb_i && !ack_reg;
    wire wb_wr      = wb_req && wb_we_i && wb_sel_i[0];
    wire idle       = (state_reg == IOB_IDLE);
    wire wr_cmd     = wb_wr && (wb_adr_i == REG_CMD) && idle;
    wire wr_addr    = wb_wr && (wb_adr_i == REG_ADDR) && idle;
    wire wr_acc     = wb_wr && (wb_adr_i == REG_ACC) && idle;
    wire go         = wr_cmd && wb_dat_i[CMD_GO_BIT];
    wire go_ident   = wb_dat_i[CMD_IDENT_BIT];
    wire busy       = !idle;
    wire [31:0] st_word = {{(32-ST_IRQ_LSB-IRQ_LINES){1'b0}}, irq_reg, 1'b0,
                           input_reg, timeout_reg, busy};
    wire [31:0] rd_mux;
    assign rd_mux = (wb_adr_i == REG_CMD)    ? 32'h0000_0000 :
                    (wb_adr_i == REG_ADDR)   ? {21'h00_0000, addr_reg} :
                    (wb_adr_i == REG_ACC)    ? {16'h0000, acc_reg} :
                    (wb_adr_i == REG_STATUS) ? st_word : 32'h0000_0000;

    // ==================== sequencer
    wire strobe_done = (cnt_reg >= 16'(STROBE_CYC - 1));
    wire tmo         = (cnt_reg >= 16'(TIMEOUT - 1));
    wire seen_ack    = bus_i.connect;
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            IOB_IDLE:   if (go) state_next = IOB_STROBE;
            IOB_STROBE: if ((seen_ack && strobe_done) || tmo) state_next = IOB_HOLD;
            IOB_HOLD:   state_next = IOB_ACC;
            default:    state_next = IOB_IDLE;
        endcase
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state_reg <= IOB_IDLE;
            cnt_reg   <= 16'h0000;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= (state_reg == IOB_STROBE) ? cnt_reg + 16'h0001 : 16'h0000;
        end
    end

    // first step: address, data and strobe rise together
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            bus_reg <= '0;
        end else if (go) begin
            bus_reg.addr         <= go_ident ? {5'h00, addr_reg[LEVEL_W-1:0]} : addr_reg;
            bus_reg.data_out     <= acc_reg;
            bus_reg.data_oe      <= 1'b1;
            bus_reg.addr_strobe  <= !go_ident;
            bus_reg.ident_strobe <= go_ident;
        end else if (state_reg == IOB_HOLD) begin
            bus_reg <= '0;                                    // release the bus
        end
    end

    // input or output is learned from the device, except that an identify command counts as input whenever it is acknowledged
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ident_reg   <= 1'b0;
            input_reg   <= 1'b0;
            timeout_reg <= 1'b0;
            hold_reg    <= ACC_RST;
        end else if (go) begin
            ident_reg   <= go_ident;
            input_reg   <= 1'b0;
            timeout_reg <= 1'b0;
        end else if (state_reg == IOB_STROBE && state_next == IOB_HOLD) begin
            timeout_reg <= !seen_ack;
            input_reg   <= seen_ack && (bus_i.input_dir || ident_reg);
            hold_reg    <= (seen_ack && (bus_i.input_dir || ident_reg)) ?
                           (ident_reg ? {7'h00, bus_i.data_in[IDENT_W-1:0]} : bus_i.data_in)
                           : acc_reg;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            acc_reg  <= ACC_RST;
            addr_reg <= ADDR_RST;
        end else begin
            if (wr_addr) addr_reg <= wb_dat_i[ADDR_W-1:0];
            if (wr_acc)
                acc_reg <= wb_dat_i[DATA_W-1:0];
            else if (state_reg == IOB_ACC)
                acc_reg <= hold_reg;
        end
    end

    // ==================== wishbone answer
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ack_reg  <= 1'b0;
            rdat_reg <= 32'h0000_0000;
            irq_reg  <= '0;
        end else begin
            ack_reg  <= wb_req;
            rdat_reg <= rd_mux;
            // level choice and level 15 stay with software; only shared lines show
            irq_reg  <= irq_i;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdat_reg;
    assign bus_o    = bus_reg;

    // ==================== checks
    chk_strobe_excl: assert property (@(posedge mclk) disable iff (reset)
        !(bus_reg.addr_strobe && bus_reg.ident_strobe))
        else $error("both strobes high");
    chk_ident_level: assert property (@(posedge mclk) disable iff (reset)
        bus_reg.ident_strobe |-> bus_reg.addr[ADDR_W-1:LEVEL_W] == '0)
        else $error("identify address above level bits");
    chk_step_order: assert property (@(posedge mclk) disable iff (reset)
        state_reg == IOB_HOLD |=> state_reg == IOB_ACC ##1 state_reg == IOB_IDLE)
        else $error("steps out of order");
    chk_wait_ack: assert property (@(posedge mclk) disable iff (reset)
        (state_reg == IOB_STROBE && !seen_ack && !tmo) |=> state_reg == IOB_STROBE)
        else $error("left strobe without acknowledge");
    chk_out_keep: assert property (@(posedge mclk) disable iff (reset)
        (state_reg == IOB_HOLD && !input_reg) |=> acc_reg == $past(acc_reg))
        else $error("output changed accumulator");
    chk_in_load: assert property (@(posedge mclk) disable iff (reset)
        state_reg == IOB_ACC |=> acc_reg == $past(hold_reg))
        else $error("accumulator not loaded");
    chk_addr_drive: assert property (@(posedge mclk) disable iff (reset)
        $rose(bus_reg.addr_strobe) |-> bus_reg.data_oe && bus_reg.addr == addr_reg)
        else $error("address and data not together");
    chk_ident_width: assert property (@(posedge mclk) disable iff (reset)
        (state_reg == IOB_ACC && ident_reg && input_reg) |-> hold_reg[DATA_W-1:IDENT_W] == '0)
        else $error("identify code wider than nine bits");
    chk_ack_pulse: assert property (@(posedge mclk) disable iff (reset)
        ack_reg |=> !ack_reg)
        else $error("acknowledge longer than one cycle");
    chk_bus_free: assert property (@(posedge mclk) disable iff (reset)
        state_reg == IOB_ACC |-> !bus_reg.data_oe && !bus_reg.addr_strobe && !bus_reg.ident_strobe)
        else $error("bus still driven after transfer");
    chk_strobe_min: assert property (@(posedge mclk) disable iff (reset)
        (state_reg == IOB_STROBE && state_next == IOB_HOLD && !tmo) |-> strobe_done)
        else $error("strobe shorter than minimum");
endmodule : iob_host
`default_nettype wire

// ==== design/iob_pkg.sv ====
// iob_pkg: constants and carrier types for the programmed i/o bus controller.
// assumes one 100 MHz clock; the device interfaces answer on the bus pins.
package iob_pkg;
    // ==================== bus geometry
    localparam int ADDR_W          = 11;
    localparam int DATA_W          = 16;
    localparam int IDENT_W         = 9;
    localparam int LEVEL_W         = 6;
    localparam int IRQ_LINES       = 4;
    localparam int FIRST_SHARED    = 10;
    // ==================== controller registers (wishbone byte addresses)
    localparam logic [3:0] REG_CMD    = 4'h0;
    localparam logic [3:0] REG_ADDR   = 4'h4;
    localparam logic [3:0] REG_ACC    = 4'h8;
    localparam logic [3:0] REG_STATUS = 4'hc;
    // ==================== command fields
    localparam int CMD_GO_BIT      = 0;
    localparam int CMD_IDENT_BIT   = 1;
    // ==================== status fields
    localparam int ST_BUSY_BIT     = 0;
    localparam int ST_TIMEOUT_BIT  = 1;
    localparam int ST_INPUT_BIT    = 2;
    localparam int ST_IRQ_LSB      = 4;
    // ==================== device status word layout
    localparam int DSW_READY_IE    = 0;
    localparam int DSW_ERR_IE      = 1;
    localparam int DSW_ACTIVE      = 2;
    localparam int DSW_READY       = 3;
    localparam int DSW_ERR_OR      = 4;
    localparam int DSW_ERR_LSB     = 5;
    localparam int DSW_UNIT_LSB    = 9;
    localparam int DSW_MODE_LSB    = 11;
    // ==================== timing
    localparam int STROBE_NS       = 100;
    localparam int CLK_NS          = 10;
    localparam int STROBE_CYC      = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int TIMEOUT_CYC     = 1000;
    // ==================== reset values
    localparam logic [DATA_W-1:0] ACC_RST  = 16'h0000;
    localparam logic [ADDR_W-1:0] ADDR_RST = 11'h000;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data_out;
        logic              data_oe;
        logic              addr_strobe;
        logic              ident_strobe;
    } iob_bus_out_t;

    typedef struct packed {
        logic              connect;
        logic              input_dir;
        logic [DATA_W-1:0] data_in;
    } iob_bus_in_t;
endpackage : iob_pkg

// ==== verification/iob_dev_model.sv ====
// iob_dev_model: one device interface on the programmed i/o bus.
// assumes the host holds its strobes until it has seen connect.
`timescale 1ns/100ps
`default_nettype none
module iob_dev_model
    import iob_pkg::*;
#(
    parameter logic [7:0] DEV_NUM    = 8'h19,
    parameter int         LEVEL      = 11,
    parameter logic [8:0] IDENT_CODE = 9'h0a5, // arbitrary value
    parameter int         DELAY      = 3
) (
    input  wire logic                  mclk,
    input  wire logic                  reset,
    input  wire iob_pkg::iob_bus_out_t bus_o,
    output iob_pkg::iob_bus_in_t       bus_i,
    output logic [3:0]                 irq
);
    // ==================== decode
    localparam logic [3:0] ERRS = 4'b0100;
    logic [15:0] data_reg, ctrl_reg, last_q, status, rd;
    logic        pend, sel, idf, ans, ident_hit;
    int          cnt;
    assign sel    = bus_o.addr_strobe && bus_o.addr[10:3] == DEV_NUM;
    assign idf    = bus_o.ident_strobe && pend && bus_o.addr[5:0] == LEVEL;
    assign status = {1'b0, ctrl_reg[14:9], ERRS, |ERRS, 1'b1, ctrl_reg[2:0]};
    assign ans    = (sel || idf) && cnt >= DELAY;
    assign rd     = idf ? {7'h0, IDENT_CODE} : (bus_o.addr[2:0] == 3'd2 ? status : data_reg);
    // released lines show the inverse of their last value, never a stale copy
    always_comb begin
        bus_i.connect   = ans;
        bus_i.input_dir = ans && (idf || !bus_o.addr[0]);
        bus_i.data_in   = bus_i.input_dir ? rd : ~last_q;
        irq             = pend ? 4'(1 << (LEVEL - FIRST_SHARED)) : 4'h0;
    end
    // ==================== state
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cnt <= 0; data_reg <= 16'h0000; ctrl_reg <= 16'h0000; pend <= 1'b0; last_q <= 16'h0000;
            ident_hit <= 1'b0;
        end else begin
            cnt    <= (sel || idf) ? (cnt < 100 ? cnt + 1 : cnt) : 0;
            last_q <= bus_i.data_in;
            if (ans && sel && bus_o.addr[0] && bus_o.addr[2:0] == 3'd1) data_reg <= bus_o.data_out;
            if (ans && sel && bus_o.addr[2:0] == 3'd3) begin
                ctrl_reg <= bus_o.data_out;
                pend     <= bus_o.data_out[0];
            end
            // the code must stand until the host ends the strobe, so clear on its fall
            if (ans && idf) ident_hit <= 1'b1;
            if (ident_hit && !bus_o.ident_strobe) begin
                pend      <= 1'b0;
                ident_hit <= 1'b0;
            end
        end
    end
endmodule : iob_dev_model
`default_nettype wire

// ==== verification/iob_host_tb.sv ====
// iob_host_tb: drives the controller over wishbone against one device model.
// assumes the controller's registers as given in its package.
`timescale 1ns/100ps
`default_nettype none
module iob_host_tb;
    import iob_pkg::*;
    logic mclk = 0, reset = 1, wb_we = 0, wb_cyc = 0, wb_stb = 0, wb_ack_o;
    logic [3:0] wb_adr = 4'h0, wb_sel = 4'h0, irq;
    logic [31:0] wb_dat = 32'h0000_0000, wb_dat_o, q;
    logic [15:0] c;
    iob_bus_out_t bus_o;
    iob_bus_in_t  bus_i;
    int err_count = 0, num_checks = 0;
    always #5 mclk = ~mclk;
    iob_host #(.TIMEOUT(20)) iob_host_inst (.mclk(mclk), .reset(reset), .wb_adr_i(wb_adr),
        .wb_dat_i(wb_dat), .wb_we_i(wb_we), .wb_sel_i(wb_sel), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .bus_o(bus_o),
        .bus_i(bus_i), .irq_i(irq));
    iob_dev_model iob_dev_model_inst (.mclk(mclk), .reset(reset), .bus_o(bus_o), .bus_i(bus_i),
        .irq(irq));
    // ==================== tasks
    task summarize;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : summarize
    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // hold the request until ack is sampled, then one idle cycle
    task wb(input logic [3:0] a, input logic we, input logic [31:0] d);
        int n;
        n = 0;
        wb_cyc <= 1; wb_stb <= 1; wb_adr <= a; wb_we <= we; wb_dat <= d; wb_sel <= 4'hf;
        do begin @(posedge mclk); n++; end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) begin err_count++; summarize(); end
        q = wb_dat_o;
        wb_cyc <= 0; wb_stb <= 0; wb_we <= 0;
        @(posedge mclk);
    endtask : wb
    task run(input logic [10:0] a, input logic [31:0] cmd);
        int n;
        n = 0;
        wb(REG_ADDR, 1, {21'h0, a});
        wb(REG_CMD, 1, cmd);
        do begin wb(REG_STATUS, 0, 0); n++; end while (q[ST_BUSY_BIT] !== 1'b0 && n < 100);
        if (n >= 100) begin err_count++; summarize(); end
    endtask : run
    // ==================== scenarios
    initial begin
        repeat (2) @(posedge mclk);
        reset <= 0;
        @(posedge mclk);
        wb(REG_ACC, 1, 32'h0000_c3a5);
        run({8'h19, 3'd1}, 1);
        check(q[ST_TIMEOUT_BIT], 1'b0);
        wb(REG_ACC, 0, 0); check(q[15:0], 16'hc3a5);
        wb(REG_ACC, 1, 32'h0000_0000);
        run({8'h19, 3'd0}, 1);
        check(q[ST_INPUT_BIT], 1'b1);
        wb(REG_ACC, 0, 0); check(q[15:0], 16'hc3a5);
        c = 16'h3607;
        wb(REG_ACC, 1, {16'h0, c});
        run({8'h19, 3'd3}, 1);
        wb(REG_STATUS, 0, 0); check(q[7:4], 4'b0010);
        run({8'h19, 3'd2}, 1);
        wb(REG_ACC, 0, 0); check(q[15:0], {1'b0, c[14:9], 4'b0100, 2'b11, c[2:0]});
        wb(REG_ADDR, 1, 32'h0000_000b);
        run(11'd11, 3);
        check(q[ST_TIMEOUT_BIT], 1'b0);
        wb(REG_ACC, 0, 0); check(q[15:0], 16'h00a5);
        wb(REG_STATUS, 0, 0); check(q[7:4], 4'b0000);
        run(11'd11, 3);
        check(q[ST_TIMEOUT_BIT], 1'b1);
        wb(REG_ACC, 0, 0); check(q[15:0], 16'h00a5);
        run({8'h33, 3'd0}, 1);
        check(q[ST_TIMEOUT_BIT], 1'b1);
        wb(4'h2, 0, 0); check(q, 32'h0000_0000);
        summarize();
    end
endmodule : iob_host_tb
`default_nettype wire
